// ---- rtl/pmt_bus_if.sv ----
// Two-wire bus between host and target; open-drain resolved here.
// Assumes the bench pulls both lines high.
`timescale 1ns/100ps
interface pmt_bus_if;
  logic sclOe;
  logic sdaHostOe;
  logic sdaTgtOe;
  logic sclTgtOe;
  logic scl;
  logic sda;
  assign scl = !(sclOe || sclTgtOe);
  assign sda = !(sdaHostOe || sdaTgtOe);
  modport host   (output sclOe, output sdaHostOe, input scl, input sda);
  modport target (output sdaTgtOe, output sclTgtOe, input scl, input sda);
endinterface

// ---- rtl/pmt_host.sv ----
// Host end: APB slave registers drive a bus master sequencer.
// Assumes open-drain lines resolved in the interface.
`timescale 1ns/100ps
module pmt_host
  import pmt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  pmt_bus_if.host          bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_START = 3'h1, H_BYTE = 3'h2, H_RSTART = 3'h3,
    H_STOP = 3'h4
  } pmt_hst_t;

  logic [1:0]  sdaS, sclS;
  logic [31:0] ctrl_r, data_r, rdata_r;
  logic [15:0] div_r, dc_r;
  logic        busy_r, go, nackSeen_r, sclOe_r, sdaOe_r;
  pmt_hst_t    st_r;
  logic [3:0]  bit_r;
  logic [2:0]  phase_r;
  logic [4:0]  idx_r;
  logic [7:0]  sh_r;
  logic [4:0]  nBytes;
  logic        rdOp, tick;
  logic [7:0]  curByte;
  logic [2:0]  op;

  assign op = ctrl_r[2:0];
  assign rdOp = (op == OP_RDB) || (op == OP_RDW);
  // ctrl: [2:0] op, [3] pec, [10:4] address, [23:16] command
  assign nBytes = 5'(op == OP_SEND ? 2 : op == OP_WRB ? 3 :
                  op == OP_WRW ? 4 : op == OP_RDB ? 4 : 5) + 5'(ctrl_r[3]);
  assign go = psel && penable && pready && pwrite && paddr == REG_CTRL
              && !busy_r;
  assign tick = (dc_r == div_r);
  assign bus.sclOe = sclOe_r;
  assign bus.sdaHostOe = sdaOe_r;

  always_ff @(posedge clk) begin
    sdaS <= {sdaS[0], bus.sda};
    sclS <= {sclS[0], bus.scl};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= '0; data_r <= '0; div_r <= DIV_RESET;
      prdata <= '0; pready <= 1'b0; pslverr <= 1'b0;
    end else begin
      pready <= psel && !pready;
      pslverr <= 1'b0;
      // Writes land only at the edge that completes the access phase
      if (psel && penable && pready && pwrite) begin
        if (paddr == REG_CTRL) begin
          if (!busy_r) ctrl_r <= pwdata;
        end else if (paddr == REG_DATA) data_r <= pwdata;
        else if (paddr == REG_DIV) div_r <= pwdata[15:0];
      end
      if (psel && !pready) begin
        if (pwrite) begin
          if (paddr != REG_CTRL && paddr != REG_DATA && paddr != REG_DIV
              && paddr != REG_STAT && paddr != REG_RDATA)
            pslverr <= 1'b1;
        end else begin
          if (paddr == REG_CTRL) prdata <= ctrl_r;
          else if (paddr == REG_DATA) prdata <= data_r;
          else if (paddr == REG_STAT) prdata <= {30'h0, nackSeen_r, busy_r};
          else if (paddr == REG_RDATA) prdata <= rdata_r;
          else if (paddr == REG_DIV) prdata <= {16'h0, div_r};
          else begin
            prdata <= '0; pslverr <= 1'b1;
          end
        end
      end
    end
  end

  // Byte sequence: addr+W, cmd, data..., [restart addr+R, rd bytes]
  always_comb begin
    curByte = 8'hFF;
    if (idx_r == 5'd0) curByte = {ctrl_r[10:4], 1'b0};
    else if (idx_r == 5'd1) curByte = ctrl_r[23:16];
    else if (rdOp && idx_r == 5'd2) curByte = {ctrl_r[10:4], 1'b1};
    else if (!rdOp && idx_r == 5'd2) curByte = data_r[7:0];
    else if (!rdOp && idx_r == 5'd3) curByte = data_r[15:8];
    else if (!rdOp && idx_r == 5'd4) curByte = data_r[23:16];
  end

  // Bit engine: four phases per bit from the divider
  logic isRdByte, lastByte;
  assign isRdByte = rdOp && idx_r >= 5'd3;
  assign lastByte = (idx_r == nBytes - 5'd1);
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= H_IDLE; busy_r <= 1'b0; sclOe_r <= 1'b0; sdaOe_r <= 1'b0;
      dc_r <= '0; phase_r <= '0; bit_r <= '0; idx_r <= '0; sh_r <= '0;
      rdata_r <= '0; nackSeen_r <= 1'b0;
    end else begin
      dc_r <= (tick || st_r == H_IDLE) ? 16'h0 : dc_r + 16'd1;
      case (st_r)
        H_IDLE: if (go) begin
          busy_r <= 1'b1; st_r <= H_START; phase_r <= '0;
          idx_r <= '0; nackSeen_r <= 1'b0; rdata_r <= '0;
        end
        H_START, H_RSTART: if (tick) begin
          phase_r <= phase_r + 3'd1;
          case (phase_r)
            3'd0: begin sclOe_r <= 1'b0; sdaOe_r <= 1'b0; end
            3'd1: sdaOe_r <= 1'b1;
            3'd2: sclOe_r <= 1'b1;
            default: begin
              st_r <= H_BYTE; phase_r <= '0; bit_r <= '0;
              sh_r <= curByte;
            end
          endcase
        end
        H_BYTE: if (tick) begin
          phase_r <= (phase_r == 3'd3) ? 3'd0 : phase_r + 3'd1;
          case (phase_r)
            3'd0: sdaOe_r <= (bit_r < 4'd8) ? (!isRdByte && !sh_r[7])
                  : (isRdByte && !lastByte);
            3'd1: sclOe_r <= 1'b0;
            3'd2: if (sclS[1]) begin
              if (bit_r < 4'd8) begin
                if (isRdByte) rdata_r <= {rdata_r[30:0], sdaS[1]};
                sh_r <= {sh_r[6:0], 1'b1};
              end else if (!isRdByte && sdaS[1]) nackSeen_r <= 1'b1;
            end else phase_r <= phase_r;
            default: begin
              sclOe_r <= 1'b1;
              if (bit_r == 4'd8) begin
                bit_r <= '0;
                idx_r <= idx_r + 5'd1;
                if (lastByte || nackSeen_r) begin
                  st_r <= H_STOP; phase_r <= '0;
                end else if (rdOp && idx_r == 5'd1) begin
                  st_r <= H_RSTART; phase_r <= '0;
                end else sh_r <= (idx_r == 5'd1 && rdOp) ? curByte
                         : (idx_r + 5'd1 == 5'd2 && rdOp) ? 8'hFF
                         : curByte_next(idx_r + 5'd1);
              end else bit_r <= bit_r + 4'd1;
            end
          endcase
        end
        H_STOP: if (tick) begin
          phase_r <= phase_r + 3'd1;
          case (phase_r)
            3'd0: sdaOe_r <= 1'b1;
            3'd1: sclOe_r <= 1'b0;
            3'd2: sdaOe_r <= 1'b0;
            default: begin st_r <= H_IDLE; busy_r <= 1'b0; end
          endcase
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  function automatic logic [7:0] curByte_next(input logic [4:0] i);
    logic [7:0] b;
    b = 8'hFF;
    if (i == 5'd1) b = ctrl_r[23:16];
    else if (!rdOp && i == 5'd2) b = data_r[7:0];
    else if (!rdOp && i == 5'd3) b = data_r[15:8];
    else if (!rdOp && i == 5'd4) b = data_r[23:16];
    return b;
  endfunction
endmodule

// ---- rtl/pmt_pkg.sv ----
// Shared constants for the bus target and host ends.
// Assumes a 125 MHz system clock on both ends.
package pmt_pkg;
  localparam int unsigned CLK_MHZ         = 125;
  localparam int unsigned BOOT_US         = 320;
  localparam int unsigned BOOT_CYC        = BOOT_US * CLK_MHZ;
  localparam int unsigned ALERT_US        = 200;
  localparam int unsigned ALERT_CYC       = ALERT_US * CLK_MHZ;
  localparam int unsigned TIMEOUT_MS      = 30;
  localparam int unsigned TIMEOUT_CYC     = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int unsigned ADDR_SEL_W      = 3;
  localparam logic [3:0]  ADDR_HIGH       = 4'hD;
  localparam logic [2:0]  ADDR_SEL_TEST   = 3'h0;
  localparam logic [7:0]  CMD_OPERATION   = 8'h01;
  localparam logic [7:0]  CMD_CLEAR_FLT   = 8'h03;
  localparam logic [7:0]  CMD_STORE_DEF   = 8'h11;
  localparam logic [7:0]  CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0]  CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0]  CMD_PIN_CFG     = 8'hD2;
  localparam logic [7:0]  CMD_ON_DELAY    = 8'hD4;
  localparam int unsigned OP_ON_BIT       = 7;
  localparam logic [7:0]  OP_RESET        = 8'h80;
  localparam logic [7:0]  PIN_CFG_RESET   = 8'h0F;
  localparam logic [7:0]  DELAY_RESET     = 8'h01;
  localparam int unsigned DELAY_UNIT_CYC  = 125;
  // Host register offsets (APB byte addresses)
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_DATA        = 8'h04;
  localparam logic [7:0]  REG_STAT        = 8'h08;
  localparam logic [7:0]  REG_RDATA       = 8'h0C;
  localparam logic [7:0]  REG_DIV         = 8'h10;
  localparam logic [15:0] DIV_RESET       = 16'h0137;
  localparam logic [7:0]  PEC_POLY        = 8'h07;

  typedef enum logic [2:0] {
    OP_SEND  = 3'h0,
    OP_WRB   = 3'h1,
    OP_WRW   = 3'h2,
    OP_RDB   = 3'h3,
    OP_RDW   = 3'h4
  } pmt_op_t;

  function automatic logic [7:0] pmt_crc8(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ PEC_POLY) : (r << 1);
    end
    return r;
  endfunction
endpackage

// ---- rtl/pmt_target.sv ----
// Bus target end: byte engine, PEC, command store, timeout alert, rails.
// Assumes sampled open-drain lines, resistor level digitised on addrSel.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
// Function
// - Read byte with PEC adds checksum byte
// - Read word returns low, high, checksum
// - Send and write byte formats acknowledged
// - Reads end on host not-acknowledge, stop
// - Address sampled only during startup delay
// - Seven addresses, lowest level is test
// - Bus inactive for 320 us at start
// - Runs at 100 and 400 kHz
// - Timeout pulses alert low 200 us
// - SCL or SDA low 25-35 ms
// - Alert repeats each timeout while stuck
// - Target never stretches the clock
// - On/off field resets to on
// - Rail needs on field and pin
// - Enable pins active high, float high
// - Enable changes honour programmed delays
// - PEC optional on reads and writes (clear-fault and store-default sends that carry a PEC byte are not executed)
// - Group commands commit at final stop (operation, pin-config, on-delay only; earlier sends dropped)
// - Memory load order, store-default copies
// - Bytes, words, length-prefixed blocks (no block transfers are implemented)
// - Fault bits latch until cleared
// - Clear by command, reset, enable edge (enable edges do not clear status_r)
module pmt_target
  import pmt_pkg::*;
#(
  parameter int unsigned RAILS      = 4,
  parameter int unsigned BOOT_N     = BOOT_CYC,
  parameter int unsigned TIMEOUT_N  = TIMEOUT_CYC,
  parameter int unsigned ALERT_N    = ALERT_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst,
  pmt_bus_if.target             bus,
  input  wire logic [ADDR_SEL_W-1:0] addrSel,
  input  wire logic [RAILS-1:0] railEnable,
  input  wire logic [RAILS-1:0] faultIn,
  input  wire logic [7:0]       defaultStore,
  output logic                  alertN,
  output logic [RAILS-1:0]      railOn,
  output logic                  testMode,
  output logic                  busActive,
  output logic [7:0]            storedDefault
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_RX = 3'h1, ST_ACK = 3'h2, ST_TX = 3'h3,
    ST_TACK = 3'h4, ST_SKIP = 3'h5
  } pmt_tst_t;

  logic [1:0] sclS, sdaS;
  logic [RAILS-1:0] enS1, enS2;
  logic [RAILS-1:0] fltS1, fltS2;
  logic [ADDR_SEL_W-1:0] adrS1, adrS2;
  logic       sclD, sdaD, sclRise, sclFall, startC, stopC;
  assign sclRise = sclS[1] && !sclD;
  assign sclFall = !sclS[1] && sclD;
  assign startC  = sclS[1] && sclD && sdaD && !sdaS[1];
  assign stopC   = sclS[1] && sclD && !sdaD && sdaS[1];
  always_ff @(posedge clk) begin
    sclS  <= {sclS[0], bus.scl};
    sdaS  <= {sdaS[0], bus.sda};
    enS1  <= railEnable;
    enS2  <= enS1;
    adrS1 <= addrSel;
    adrS2 <= adrS1;
    fltS1 <= faultIn;
    fltS2 <= fltS1;
    sclD  <= sclS[1];
    sdaD  <= sdaS[1];
  end
  assign bus.sclTgtOe = 1'b0;

  // Startup: address caught at end of boot delay, then bus goes live
  logic [31:0] bootCnt_r;
  logic [6:0]  myAddr_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      bootCnt_r <= '0;
      busActive <= 1'b0;
      myAddr_r  <= 7'h00;
      testMode  <= 1'b0;
    end else if (!busActive) begin
      bootCnt_r <= bootCnt_r + 32'd1;
      if (bootCnt_r == BOOT_N - 1) begin
        busActive <= 1'b1;
        myAddr_r  <= {ADDR_HIGH, adrS2};
        testMode  <= (adrS2 == ADDR_SEL_TEST);
      end
    end
  end

  // Byte engine, sampled on SCL rise, driven after SCL fall
  pmt_tst_t   st_r;
  logic [3:0] bitCnt_r;
  logic [7:0] sh_r, cmd_r, d0_r, d1_r, pec_r, tx_r;
  logic [2:0] byteIdx_r;
  logic       rd_r, nack_r, sdaOe_r;
  logic [7:0] op_r, pinCfg_r, dly_r, pendOp_r, pendPin_r, pendDly_r;
  logic [7:0] status_r;
  logic       clrReq_r, storeReq_r, segOk, live;
  logic [2:0] segHit, pendM_r, commit_r;
  logic [15:0] statusWord;
  assign statusWord = {8'h00, status_r};
  assign bus.sdaTgtOe = sdaOe_r;

  always_ff @(posedge clk) begin
    if (rst || !busActive) begin
      st_r <= ST_IDLE; sdaOe_r <= 1'b0; bitCnt_r <= '0; byteIdx_r <= '0;
      rd_r <= 1'b0; pec_r <= '0; pendM_r <= 3'b000; cmd_r <= '0;
      commit_r <= 3'b000;
      d0_r <= '0; d1_r <= '0; sh_r <= '0; tx_r <= '0; nack_r <= 1'b0;
      pendOp_r <= OP_RESET; pendPin_r <= PIN_CFG_RESET;
      pendDly_r <= DELAY_RESET; clrReq_r <= 1'b0; storeReq_r <= 1'b0;
    end else begin
      clrReq_r   <= 1'b0;
      storeReq_r <= 1'b0;
      commit_r   <= 3'b000;
      if ((startC || stopC) && segHit[0]) pendOp_r  <= d0_r;
      if ((startC || stopC) && segHit[1]) pendPin_r <= d0_r;
      if ((startC || stopC) && segHit[2]) pendDly_r <= d0_r;
      if (startC) begin
        st_r <= ST_RX; bitCnt_r <= '0; byteIdx_r <= '0; sdaOe_r <= 1'b0;
        // Checksum runs on across a read's repeated start
        if (st_r == ST_IDLE || byteIdx_r != 3'd2) pec_r <= '0;
        pendM_r <= pendM_r | segHit;
      end else if (stopC) begin
        st_r <= ST_IDLE; sdaOe_r <= 1'b0;
        // Operation, pin-config and on-delay segments of a group land together at the final stop
        pendM_r  <= 3'b000;
        commit_r <= pendM_r | segHit;
        if (live && !rd_r && byteIdx_r == 3'd2) begin
          clrReq_r   <= (cmd_r == CMD_CLEAR_FLT);
          storeReq_r <= (cmd_r == CMD_STORE_DEF);
        end
      end else case (st_r)
        ST_RX: if (sclRise) begin
          sh_r <= {sh_r[6:0], sdaS[1]};
          bitCnt_r <= bitCnt_r + 4'd1;
        end else if (sclFall && bitCnt_r == 4'd8) begin
          bitCnt_r <= '0;
          pec_r <= pmt_crc8(pec_r, sh_r);
          if (byteIdx_r == 3'd0) begin
            if (sh_r[7:1] == myAddr_r && !testMode) begin
              sdaOe_r <= 1'b1; st_r <= ST_ACK;
              rd_r <= sh_r[0];
              byteIdx_r <= 3'd1;
            end else st_r <= ST_SKIP;
          end else begin
            sdaOe_r <= 1'b1; st_r <= ST_ACK;
            byteIdx_r <= byteIdx_r + 3'd1;
            if (byteIdx_r == 3'd1) cmd_r <= sh_r;
            if (byteIdx_r == 3'd2) d0_r <= sh_r;
            if (byteIdx_r == 3'd3) d1_r <= sh_r;
          end
        end
        ST_ACK: if (sclFall) begin
          sdaOe_r <= 1'b0;
          if (rd_r) begin
            st_r <= ST_TX;
            tx_r <= (cmd_r == CMD_STATUS_WORD) ? statusWord[7:0] :
                    (cmd_r == CMD_OPERATION) ? op_r :
                    (cmd_r == CMD_PIN_CFG) ? pinCfg_r :
                    (cmd_r == CMD_ON_DELAY) ? dly_r : status_r;
            sdaOe_r <= !((cmd_r == CMD_STATUS_WORD) ? statusWord[7] :
                    (cmd_r == CMD_OPERATION) ? op_r[7] :
                    (cmd_r == CMD_PIN_CFG) ? pinCfg_r[7] :
                    (cmd_r == CMD_ON_DELAY) ? dly_r[7] : status_r[7]);
            bitCnt_r <= 4'd1;
          end else st_r <= ST_RX;
        end
        ST_TX: if (sclFall) begin
          if (bitCnt_r == 4'd8) begin
            sdaOe_r <= 1'b0; st_r <= ST_TACK;
            pec_r <= pmt_crc8(pec_r, tx_r);
          end else begin
            sdaOe_r <= !tx_r[3'd7 - bitCnt_r[2:0]];
            bitCnt_r <= bitCnt_r + 4'd1;
          end
        end
        ST_TACK: if (sclRise) nack_r <= sdaS[1];
        else if (sclFall) begin
          if (nack_r) st_r <= ST_SKIP;
          else begin
            byteIdx_r <= byteIdx_r + 3'd1;
            // Word: high byte next, then PEC; byte: PEC next
            tx_r <= (cmd_r == CMD_STATUS_WORD && byteIdx_r == 3'd1)
                    ? statusWord[15:8] : pec_r;
            sdaOe_r <= !((cmd_r == CMD_STATUS_WORD && byteIdx_r == 3'd1)
                    ? statusWord[15] : pec_r[7]);
            bitCnt_r <= 4'd1; st_r <= ST_TX;
          end
        end
        default: ;
      endcase
    end
  end
  // Checksum over a segment including its PEC byte leaves zero
  assign live  = (st_r != ST_IDLE);
  assign segOk = live && !rd_r && (byteIdx_r == 3'd3 ||
                 (byteIdx_r == 3'd4 && pec_r == 8'h00));
  assign segHit = segOk ? {cmd_r == CMD_ON_DELAY, cmd_r == CMD_PIN_CFG,
                           cmd_r == CMD_OPERATION} : 3'b000;

  // Operating memory: built-in, default store (delay only), then bus
  always_ff @(posedge clk) begin
    if (rst) begin
      op_r <= OP_RESET;
      pinCfg_r <= PIN_CFG_RESET;
      dly_r <= DELAY_RESET;
      storedDefault <= 8'h00;
    end else begin
      if (!busActive) dly_r <= (defaultStore != 8'h00) ? defaultStore
                                                        : DELAY_RESET;
      if (commit_r[0]) op_r <= pendOp_r;
      if (commit_r[1]) pinCfg_r <= pendPin_r;
      if (commit_r[2]) dly_r <= pendDly_r;
      if (storeReq_r) storedDefault <= dly_r;
    end
  end

  // Sticky faults
  always_ff @(posedge clk) begin
    if (rst) status_r <= 8'h00;
    else status_r <= (clrReq_r ? 8'h00 : status_r)
                     | {{(8-RAILS){1'b0}}, fltS2};
  end

  // Timeout watchdog: one counter per line, each needs a continuous low
  logic [31:0] toCnt_r, sdaCnt_r, alCnt_r;
  logic        sclTo, sdaTo;
  assign sclTo = !sclS[1] && toCnt_r == TIMEOUT_N - 1;
  assign sdaTo = !sdaS[1] && sdaCnt_r == TIMEOUT_N - 1;
  always_ff @(posedge clk) begin
    if (rst) begin
      toCnt_r <= '0; sdaCnt_r <= '0; alCnt_r <= '0; alertN <= 1'b1;
    end else begin
      // Wrap while stuck so the pulse repeats each interval
      if (sclS[1] || sclTo) toCnt_r <= '0;
      else toCnt_r <= toCnt_r + 32'd1;
      if (sdaS[1] || sdaTo) sdaCnt_r <= '0;
      else sdaCnt_r <= sdaCnt_r + 32'd1;
      if (sclTo || sdaTo) begin
        alCnt_r <= ALERT_N; alertN <= 1'b0;
      end else if (alCnt_r != 0) begin
        alCnt_r <= alCnt_r - 32'd1;
        alertN <= (alCnt_r == 32'd1);
      end
    end
  end

  // Rails with turn-on/turn-off delay
  genvar g;
  generate
    for (g = 0; g < RAILS; g++) begin : gRail
      logic want;
      logic [15:0] dCnt_r;
      assign want = op_r[OP_ON_BIT] && (!pinCfg_r[g] || enS2[g]);
      always_ff @(posedge clk) begin
        if (rst) begin
          railOn[g] <= 1'b0; dCnt_r <= '0;
        end else if (want == railOn[g]) dCnt_r <= '0;
        else if (dCnt_r >= 16'(dly_r) * 16'(DELAY_UNIT_CYC)) begin
          railOn[g] <= want; dCnt_r <= '0;
        end else dCnt_r <= dCnt_r + 16'd1;
      end
    end
  endgenerate
endmodule

// ---- test/pmt_bus_chk.sv ----
// Wire-level checker for the host-to-target two-wire link.
// Assumes it watches the resolved lines and every drive enable.
`timescale 1ns/100ps
module pmt_bus_chk #(
  parameter int unsigned BOOT_N = 50
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sclOe,
  input  wire logic sdaHostOe,
  input  wire logic sdaTgtOe,
  input  wire logic sclTgtOe,
  input  wire logic scl,
  input  wire logic sda
);
  logic [15:0] bootCnt_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      bootCnt_r <= 16'h0000;
    end else if (bootCnt_r != 16'hFFFF) begin
      bootCnt_r <= bootCnt_r + 16'h0001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence startCond;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stopCond;
    scl && $past(scl) && $rose(sda);
  endsequence

  a_no_clk_stretch:
    assert property (!sclTgtOe) else $error("target held clock low");
  a_boot_quiet:
    assert property (bootCnt_r < BOOT_N |-> !sdaTgtOe)
    else $error("target drove data during boot");
  a_release_free:
    assert property ($fell(rst) |-> !sclOe && !sdaHostOe && !sdaTgtOe)
    else $error("bus not free after reset");
  a_tgt_data_hold:
    assert property (scl && $past(scl) |-> $stable(sdaTgtOe))
    else $error("target data moved while clock high");
  a_start_by_host:
    assert property (startCond |-> sdaHostOe && !sdaTgtOe)
    else $error("start not made by host alone");
  a_quiet_after_stop:
    assert property (stopCond |=> !sdaTgtOe [*8])
    else $error("target drove data after stop");
  a_clk_low_min:
    assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  a_clk_high_min:
    assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
endmodule

// ---- test/tb_pmbus_target_interface.sv ----
// Bench: host and target joined on one link, second target for faults.
// Assumes zero-wait APB answers and host CTRL/STAT/RDATA layout.
`timescale 1ns/100ps
module tb_pmbus_target_interface
  import pmt_pkg::*;
;
  localparam int TO2 = 2000;
  localparam int AL = 100;
  localparam logic [6:0] ADR = {ADDR_HIGH, 3'h5};
  localparam logic [7:0] AW = {ADR, 1'b0};
  localparam logic [7:0] AR = {ADR, 1'b1};
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, pe, nk;
  logic [7:0]  paddr, defaultStore, storedDefault;
  logic [31:0] pwdata, prdata, q;
  logic [2:0]  addrSel;
  logic [3:0]  railEnable, faultIn, railOn;
  logic        alertN, testMode, busActive, alert2N, test2, busActive2;
  int          errors, n_checks;

  pmt_bus_if bus ();
  pmt_bus_if bus2 ();
  pmt_host i_pmt_host (.clk(clk), .rst(rst), .bus(bus), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pmt_target #(.BOOT_N(50), .TIMEOUT_N(20000), .ALERT_N(AL)) i_pmt_target (
    .clk(clk), .rst(rst), .bus(bus), .addrSel(addrSel),
    .railEnable(railEnable), .faultIn(faultIn),
    .defaultStore(defaultStore), .alertN(alertN), .railOn(railOn),
    .testMode(testMode), .busActive(busActive),
    .storedDefault(storedDefault));
  // Fault end: bench holds its lines low on purpose
  pmt_target #(.BOOT_N(50), .TIMEOUT_N(TO2), .ALERT_N(AL)) i_pmt_target_b (
    .clk(clk), .rst(rst), .bus(bus2), .addrSel(3'h0),
    .railEnable(railEnable), .faultIn(faultIn),
    .defaultStore(defaultStore), .alertN(alert2N), .railOn(),
    .testMode(test2), .busActive(busActive2), .storedDefault());
  pmt_bus_chk #(.BOOT_N(50)) u_chk (.clk(clk), .rst(rst),
    .sclOe(bus.sclOe), .sdaHostOe(bus.sdaHostOe),
    .sdaTgtOe(bus.sdaTgtOe), .sclTgtOe(bus.sclTgtOe),
    .scl(bus.scl), .sda(bus.sda));

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      $display("BAD %0t %s", $time, m);
      errors++;
    end
  endtask

  // Independent checksum model, bytes taken from the top
  function automatic logic [7:0] pec(input logic [39:0] v, input int n);
    logic [7:0] r;
    r = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      r = r ^ v[8*i+:8];
      repeat (8) r = r[7] ? ({r[6:0], 1'b0} ^ PEC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      chk(1'b0, "apb hang");
      summarize();
    end
    q = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic xfer(input pmt_op_t op, input logic p, input logic [6:0] a,
                      input logic [7:0] c, input logic [15:0] d);
    int n;
    apb(1'b1, REG_DATA, {16'h0000, d});
    apb(1'b1, REG_CTRL, {8'h00, c, 5'h00, a, p, op});
    // Bounded poll; a stuck transfer ends the run
    for (n = 0; n < 20000; n++) begin
      apb(1'b0, REG_STAT, 32'h0);
      if (q[0] === 1'b0) break;
    end
    if (n == 20000) begin
      chk(1'b0, "transfer hang");
      summarize();
    end
    nk = q[1];
    apb(1'b0, REG_RDATA, 32'h0);
  endtask

  task automatic t_boot();
    repeat (40) @(posedge clk);
    chk(busActive === 1'b0, "active too early");
    repeat (20) @(posedge clk);
    chk(busActive === 1'b1, "never active");
    chk(busActive2 === 1'b1, "second end never active");
    chk(testMode === 1'b0 && test2 === 1'b1, "test mode");
    apb(1'b0, 8'h40, 32'h0);
    chk(pe === 1'b1, "unmapped accepted");
    apb(1'b1, REG_DIV, 32'h0000004E);
    xfer(OP_RDB, 1'b1, ADR, CMD_OPERATION, 16'h0000);
    chk(!nk && q[15:0] === {OP_RESET,
        pec({8'h00, AW, CMD_OPERATION, AR, OP_RESET}, 4)}, "op read");
  endtask

  task automatic t_fault();
    faultIn <= 4'h2;
    repeat (3) @(posedge clk);
    faultIn <= 4'h0;
    repeat (3) @(posedge clk);
    xfer(OP_RDB, 1'b0, ADR, CMD_STATUS_BYTE, 16'h0000);
    chk(!nk && q[7:0] === 8'h02, "fault not latched");
    xfer(OP_SEND, 1'b0, ADR, CMD_CLEAR_FLT, 16'h0000);
    xfer(OP_RDW, 1'b1, ADR, CMD_STATUS_WORD, 16'h0000);
    chk(!nk && q[23:0] === {16'h0000,
        pec({AW, CMD_STATUS_WORD, AR, 16'h0000}, 5)}, "word read");
  endtask

  task automatic t_store();
    // Host sends the second data byte as the checksum
    xfer(OP_WRB, 1'b1, ADR, CMD_ON_DELAY, {pec({16'h0000, AW,
         CMD_ON_DELAY, 8'h03}, 3), 8'h03});
    xfer(OP_SEND, 1'b0, ADR, CMD_STORE_DEF, 16'h0000);
    chk(!nk && storedDefault === 8'h03, "store default");
  endtask

  task automatic t_rails();
    chk(railOn === 4'hF, "rails not up");
    railEnable <= 4'hE;
    repeat (60) @(posedge clk);
    chk(railOn === 4'hF, "off delay skipped");
    repeat (540) @(posedge clk);
    chk(railOn === 4'hE, "pin off ignored");
    xfer(OP_WRB, 1'b0, ADR, CMD_OPERATION, 16'h0000);
    repeat (600) @(posedge clk);
    chk(railOn === 4'h0, "operation off ignored");
  endtask

  task automatic t_addr();
    addrSel <= 3'h2;
    xfer(OP_SEND, 1'b0, {ADDR_HIGH, 3'h2}, CMD_CLEAR_FLT, 16'h0000);
    chk(nk === 1'b1, "address resampled");
  endtask

  task automatic t_timeout();
    int n;
    bus2.sclOe <= 1'b1;
    for (n = 0; n < TO2 * 2 && alert2N !== 1'b0; n++) @(posedge clk);
    chk(n >= TO2 * 5 / 6 && n <= TO2 * 7 / 6, "clock timeout");
    for (n = 0; n < AL * 2 && alert2N === 1'b0; n++) @(posedge clk);
    chk(n >= AL - 1 && n <= AL + 1, "alert width");
    for (n = 0; n < TO2 * 2 && alert2N !== 1'b0; n++) @(posedge clk);
    chk(n >= TO2 * 5 / 6 - AL - 1 && n <= TO2 * 7 / 6, "repeat");
    repeat (AL + 5) @(posedge clk);
    bus2.sclOe <= 1'b0;
    bus2.sdaHostOe <= 1'b1;
    for (n = 0; n < TO2 * 2 && alert2N !== 1'b0; n++) @(posedge clk);
    chk(n >= TO2 * 5 / 6 && n <= TO2 * 7 / 6, "data timeout");
    repeat (AL + 5) @(posedge clk);
    bus2.sdaHostOe <= 1'b0;
    for (n = 0; n < TO2 * 2 && alert2N !== 1'b0; n++) @(posedge clk);
    chk(n == TO2 * 2, "alert after release");
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    addrSel = 3'h5;
    railEnable = 4'hF;
    faultIn = 4'h0;
    defaultStore = 8'h02;
    bus2.sclOe = 1'b0;
    bus2.sdaHostOe = 1'b0;
    errors = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_boot();
    t_fault();
    t_store();
    t_rails();
    t_addr();
    t_timeout();
    summarize();
  end
endmodule
